// *** core/rxirq_core.v ***
// Interrupt aggregation core: source grouping, register port and interrupt pins
`include "rxirq_regs.vh"

// Contract
// - No second pin assertion while one pending
// - Sync status at 0x43 and 0x5c, forced status at 0x48
// - Level status at 0x61, 0x66, 0x6b, 0x70
// - Edge status 0x7a to 0x8e, step five
// - Sync valid, lock, unlock: edge or level
// - CEC raw bits latch until cleared
// - Level raw bits need no clearing
// - Edge raw bits held until cleared
// - 0x41[4] picks valid rise or both
// - 0x41[5] picks lock rise or both
// - Lock bit 2, unlock bit 3 at 0x43; lock bit 3, unlock bit 2 at 0x5c; read-only
// - Clock and cable events valid always
// - All masks zero after reset
// - Level raw mirrors live source state
// - Edge raw latches a momentary event
module rxirq_core #(
    parameter NGRP = 14
) (
    input wire clock,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire sync_timing_valid_live,
    input wire proc_lock_live,
    input wire proc_unlock_live,
    input wire ch1_sync_valid_live,
    input wire ch1_lock_live,
    input wire ch1_unlock_live,
    input wire [27:0] level_src,
    input wire port_a_clock_present,
    input wire port_b_clock_present,
    input wire port_a_cable_present,
    input wire port_b_cable_present,
    input wire [3:0] input_format_select,
    input wire [39:0] edge_pulse,
    input wire [5:0] cec_flag_pulse,
    input wire [7:0] cec_byte_pulse,
    output reg irq_out_primary,
    output reg irq_out_secondary,
    output reg hdmi_mode_active
);
    localparam W = 8 * NGRP;

    reg [7:0] ctrl_a_ff;
    reg [7:0] ctrl_b_ff;
    reg [7:0] mask1_ff [0:NGRP-1];
    reg [7:0] mask2_ff [0:NGRP-1];
    reg [7:0] nxt_rdata;
    reg nxt_irq1;
    reg nxt_irq2;
    reg ctrl_hit;
    integer gi;
    integer ri;

    wire [W-1:0] g_src;
    wire [W-1:0] g_pulse;
    wire [W-1:0] g_lvl;
    wire [W-1:0] g_sedge;
    wire [W-1:0] g_rise;
    wire [W-1:0] g_raw;
    wire [W-1:0] g_st;
    wire [NGRP-1:0] g_clr;
    wire [NGRP-1:0] g_p1;
    wire [NGRP-1:0] g_p2;

    wire stim;
    wire store_unmasked;
    wire valid_both_sel;
    wire lock_both_sel;
    wire sec_enable;
    wire [7:0] sync_valid_flag;
    wire [7:0] sync_lock_flags;
    wire [7:0] chan_valid_flag;
    wire [7:0] chan_lock_flags;

    // Status offset of each group
    function [7:0] st_off;
        input integer g;
        begin
            case (g)
                0: st_off = `RXIRQ_ST_SYNC;
                1: st_off = `RXIRQ_ST_FORCED;
                2: st_off = `RXIRQ_ST_CHAN;
                3: st_off = `RXIRQ_ST_LVL_PKT;
                4: st_off = `RXIRQ_ST_LVL_AUD;
                5: st_off = `RXIRQ_ST_LVL_VID;
                6: st_off = `RXIRQ_ST_LVL_CAB;
                7: st_off = `RXIRQ_ST_EDG_PKT;
                8: st_off = `RXIRQ_ST_EDG_FIFO;
                9: st_off = `RXIRQ_ST_EDG_UPD;
                10: st_off = `RXIRQ_ST_EDG_CKS;
                11: st_off = `RXIRQ_ST_EDG_MEAS;
                12: st_off = `RXIRQ_ST_CEC_FLAG;
                default: st_off = `RXIRQ_ST_CEC_BYTE;
            endcase
        end
    endfunction

    // Control fields
    assign stim = ctrl_a_ff[`RXIRQ_STIM_BIT];
    assign store_unmasked = ctrl_a_ff[`RXIRQ_STORE_BIT];
    assign valid_both_sel = ctrl_b_ff[`RXIRQ_VALID_SEL_BIT];
    assign lock_both_sel = ctrl_b_ff[`RXIRQ_LOCK_SEL_BIT];
    assign sec_enable = |ctrl_b_ff[`RXIRQ_SEC_EN_HI:`RXIRQ_SEC_EN_LO];

    // Field masks for the sync groups
    assign sync_valid_flag = 8'h01 << `RXIRQ_SYNC_VALID_BIT;
    assign sync_lock_flags = (8'h01 << `RXIRQ_SYNC_LOCK_BIT) | (8'h01 << `RXIRQ_SYNC_UNLOCK_BIT);
    assign chan_valid_flag = 8'h01 << `RXIRQ_CH1_VALID_BIT;
    assign chan_lock_flags = (8'h01 << `RXIRQ_CH1_LOCK_BIT) | (8'h01 << `RXIRQ_CH1_UNLOCK_BIT);

    // Lock at 2, unlock at 3
    assign g_src[7:0] = {3'h0, sync_timing_valid_live, proc_unlock_live, proc_lock_live, 2'h0};
    assign g_pulse[7:0] = 8'h00;
    assign g_sedge[7:0] = sync_valid_flag | sync_lock_flags;
    assign g_lvl[7:0] = ({8{valid_both_sel}} & sync_valid_flag) | ({8{lock_both_sel}} & sync_lock_flags);
    assign g_rise[7:0] = ({8{~valid_both_sel}} & sync_valid_flag) | ({8{~lock_both_sel}} & sync_lock_flags);

    // Forced interrupt, latched on the control bit rising
    assign g_src[15:8] = {stim, 7'h00};
    assign g_pulse[15:8] = 8'h00;
    assign g_sedge[15:8] = 8'h01 << `RXIRQ_FORCED_BIT;
    assign g_lvl[15:8] = 8'h00;
    assign g_rise[15:8] = 8'h01 << `RXIRQ_FORCED_BIT;

    assign g_src[23:16] = {4'h0, ch1_lock_live, ch1_unlock_live, ch1_sync_valid_live, 1'b0};
    assign g_pulse[23:16] = 8'h00;
    assign g_sedge[23:16] = chan_valid_flag | chan_lock_flags;
    assign g_lvl[23:16] = ({8{valid_both_sel}} & chan_valid_flag) | ({8{lock_both_sel}} & chan_lock_flags);
    assign g_rise[23:16] = ({8{~valid_both_sel}} & chan_valid_flag) | ({8{~lock_both_sel}} & chan_lock_flags);

    // Clock and cable in last byte
    assign g_src[55:24] = {
        level_src[27:24],
        port_b_cable_present,
        port_a_cable_present,
        port_b_clock_present,
        port_a_clock_present,
        level_src[23:0]
    };
    assign g_pulse[55:24] = 32'h00000000;
    assign g_lvl[55:24] = 32'hffffffff;
    assign g_sedge[55:24] = 32'h00000000;
    assign g_rise[55:24] = 32'h00000000;

    assign g_src[95:56] = 40'h0000000000;
    assign g_pulse[95:56] = edge_pulse;
    assign g_lvl[95:56] = 40'h0000000000;
    assign g_sedge[95:56] = 40'h0000000000;
    assign g_rise[95:56] = 40'h0000000000;

    assign g_src[111:96] = 16'h0000;
    assign g_pulse[111:96] = {cec_byte_pulse, 2'h0, cec_flag_pulse};
    assign g_lvl[111:96] = 16'h0000;
    assign g_sedge[111:96] = 16'h0000;
    assign g_rise[111:96] = 16'h0000;

    // One instance per group
    genvar g;
    generate
        for (g = 0; g < NGRP; g = g + 1) begin : grp
            assign g_clr[g] = reg_wr && (reg_addr == st_off(g) + `RXIRQ_CLR_ABOVE);

            rxirq_group u_group (
                .clock(clock),
                .reset(reset),
                .src(g_src[8*g+7:8*g]),
                .pulse(g_pulse[8*g+7:8*g]),
                .is_level(g_lvl[8*g+7:8*g]),
                .src_edge(g_sedge[8*g+7:8*g]),
                .rise_only(g_rise[8*g+7:8*g]),
                .clr_wr(g_clr[g]),
                .clr_bits(reg_wdata),
                .mask1(mask1_ff[g]),
                .mask2(mask2_ff[g]),
                .store_unmasked(store_unmasked),
                .raw(g_raw[8*g+7:8*g]),
                .status(g_st[8*g+7:8*g]),
                .pend1(g_p1[g]),
                .pend2(g_p2[g])
            );
        end
    endgenerate

    // Control and mask register writes
    always @(posedge clock) begin
        if (reset) begin
            ctrl_a_ff <= `RXIRQ_CTRL_A_RST;
            ctrl_b_ff <= `RXIRQ_CTRL_B_RST;
            for (gi = 0; gi < NGRP; gi = gi + 1) begin
                mask1_ff[gi] <= 8'h00;
                mask2_ff[gi] <= 8'h00;
            end
        end else if (reg_wr) begin
            if (reg_addr == `RXIRQ_CTRL_A) begin
                ctrl_a_ff <= reg_wdata;
            end else if (reg_addr == `RXIRQ_CTRL_B) begin
                ctrl_b_ff <= reg_wdata;
            end else begin
                for (gi = 0; gi < NGRP; gi = gi + 1) begin
                    if (reg_addr == st_off(gi) + `RXIRQ_MB1_ABOVE) begin
                        mask1_ff[gi] <= reg_wdata;
                    end else if (reg_addr == st_off(gi) + `RXIRQ_MB2_ABOVE) begin
                        mask2_ff[gi] <= reg_wdata;
                    end
                end
            end
        end
    end

    // Read decode; clear and unmapped addresses read zero
    always @* begin
        nxt_rdata = 8'h00;
        ctrl_hit = 1'b0;
        if (reg_addr == `RXIRQ_CTRL_A) begin
            nxt_rdata = ctrl_a_ff;
            ctrl_hit = 1'b1;
        end else if (reg_addr == `RXIRQ_CTRL_B) begin
            nxt_rdata = ctrl_b_ff;
            ctrl_hit = 1'b1;
        end
        for (ri = 0; ri < NGRP; ri = ri + 1) begin
            if (ctrl_hit) begin
                nxt_rdata = nxt_rdata;
            end else if (reg_addr == st_off(ri)) begin
                nxt_rdata = g_st[8*ri +: 8];
            end else if (reg_addr == st_off(ri) - `RXIRQ_RAW_BELOW) begin
                nxt_rdata = g_raw[8*ri +: 8];
            end else if (reg_addr == st_off(ri) + `RXIRQ_MB2_ABOVE) begin
                nxt_rdata = mask2_ff[ri];
            end else if (reg_addr == st_off(ri) + `RXIRQ_MB1_ABOVE) begin
                nxt_rdata = mask1_ff[ri];
            end
        end
    end

    // Pin levels from pending, masked status
    always @* begin
        nxt_irq1 = |g_p1;
        nxt_irq2 = sec_enable & (|g_p2);
    end

    // Registered outputs
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            irq_out_primary <= 1'b0;
            irq_out_secondary <= 1'b0;
            hdmi_mode_active <= 1'b0;
        end else begin
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
            irq_out_primary <= nxt_irq1;
            irq_out_secondary <= nxt_irq2;
            hdmi_mode_active <= (input_format_select == `RXIRQ_FMT_HDMI_A) ||
                (input_format_select == `RXIRQ_FMT_HDMI_B);
        end
    end
endmodule

// *** core/rxirq_regs.vh ***
// Register map, field positions and reset values of the interrupt status block
`ifndef RXIRQ_REGS_VH
`define RXIRQ_REGS_VH

// Control registers
`define RXIRQ_CTRL_A 8'h40
`define RXIRQ_CTRL_B 8'h41
`define RXIRQ_CTRL_A_RST 8'h00
`define RXIRQ_CTRL_B_RST 8'h30

// Control field positions
`define RXIRQ_STIM_BIT 2
`define RXIRQ_STORE_BIT 4
`define RXIRQ_VALID_SEL_BIT 4
`define RXIRQ_LOCK_SEL_BIT 5
`define RXIRQ_SEC_EN_HI 1
`define RXIRQ_SEC_EN_LO 0

// Status register offsets, one per group
`define RXIRQ_ST_SYNC 8'h43
`define RXIRQ_ST_FORCED 8'h48
`define RXIRQ_ST_CHAN 8'h5c
`define RXIRQ_ST_LVL_PKT 8'h61
`define RXIRQ_ST_LVL_AUD 8'h66
`define RXIRQ_ST_LVL_VID 8'h6b
`define RXIRQ_ST_LVL_CAB 8'h70
`define RXIRQ_ST_EDG_PKT 8'h7a
`define RXIRQ_ST_EDG_FIFO 8'h7f
`define RXIRQ_ST_EDG_UPD 8'h84
`define RXIRQ_ST_EDG_CKS 8'h89
`define RXIRQ_ST_EDG_MEAS 8'h8e
`define RXIRQ_ST_CEC_FLAG 8'h98
`define RXIRQ_ST_CEC_BYTE 8'h9d

// Neighbours of each status register, as distance from it
`define RXIRQ_RAW_BELOW 8'h01
`define RXIRQ_CLR_ABOVE 8'h01
`define RXIRQ_MB2_ABOVE 8'h02
`define RXIRQ_MB1_ABOVE 8'h03

// Field positions inside the sync and forced groups
`define RXIRQ_SYNC_VALID_BIT 4
`define RXIRQ_SYNC_UNLOCK_BIT 3
`define RXIRQ_SYNC_LOCK_BIT 2
`define RXIRQ_FORCED_BIT 7
`define RXIRQ_CH1_LOCK_BIT 3
`define RXIRQ_CH1_UNLOCK_BIT 2
`define RXIRQ_CH1_VALID_BIT 1

// Input format codes that mean the digital link mode
`define RXIRQ_FMT_HDMI_A 4'h5
`define RXIRQ_FMT_HDMI_B 4'h6

`endif

// *** core/rxirq_group.v ***
// One byte-wide group of raw, latched status and mask-qualified pending bits
module rxirq_group (
    input wire clock,
    input wire reset,
    input wire [7:0] src,
    input wire [7:0] pulse,
    input wire [7:0] is_level,
    input wire [7:0] src_edge,
    input wire [7:0] rise_only,
    input wire clr_wr,
    input wire [7:0] clr_bits,
    input wire [7:0] mask1,
    input wire [7:0] mask2,
    input wire store_unmasked,
    output wire [7:0] raw,
    output wire [7:0] status,
    output wire pend1,
    output wire pend2
);
    reg [7:0] src_d_ff;
    reg [7:0] latch_ff;
    reg [7:0] status_ff;
    wire [7:0] rise;
    wire [7:0] chg;
    wire [7:0] src_evt;
    wire [7:0] use_src;
    wire [7:0] evt;
    wire [7:0] clr;
    wire [7:0] take;
    wire [7:0] nxt_latch;
    wire [7:0] nxt_status;

    // Edge detection on the live sources
    assign rise = src & ~src_d_ff;
    assign chg = src ^ src_d_ff;
    assign src_evt = (rise_only & rise) | (~rise_only & chg);
    assign use_src = is_level | src_edge;
    assign evt = (use_src & src_evt) | (~use_src & pulse);

    // Clear strobe, one cycle wide
    assign clr = clr_wr ? clr_bits : 8'h00;
    assign take = evt & (mask1 | mask2 | {8{store_unmasked}});

    assign nxt_latch = (latch_ff & ~clr) | (evt & ~is_level);
    assign nxt_status = (status_ff & ~clr) | take;

    assign raw = (is_level & src) | (~is_level & latch_ff);
    assign status = status_ff;

    // Pending per pin
    assign pend1 = |(status_ff & mask1);
    assign pend2 = |(status_ff & mask2);

    // State update
    always @(posedge clock) begin
        if (reset) begin
            src_d_ff <= 8'h00;
            latch_ff <= 8'h00;
            status_ff <= 8'h00;
        end else begin
            src_d_ff <= src;
            latch_ff <= nxt_latch;
            status_ff <= nxt_status;
        end
    end
endmodule

// *** sim/rxirq_props.sv ***
// Timing checker for the interrupt pins, read port and mode flag
module rxirq_props (
    input wire clock,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [3:0] input_format_select,
    input wire [39:0] edge_pulse,
    input wire irq_out_primary,
    input wire irq_out_secondary,
    input wire hdmi_mode_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_seen_ff;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // Remembers whether any register write came since reset
    always @(posedge clock) begin
        wr_seen_ff <= !reset && (wr_seen_ff || reg_wr);
    end
    property p_mode; 1'b1 |=> hdmi_mode_active == ($past(input_format_select) inside {4'h5, 4'h6}); endproperty
    property p_rst_quiet; $fell(reset) |-> !irq_out_primary && !irq_out_secondary; endproperty
    property p_no_mask; !wr_seen_ff |=> !irq_out_primary && !irq_out_secondary; endproperty
    property p_hold_pri; $fell(irq_out_primary) |-> $past(reg_wr, 2); endproperty
    property p_hold_sec; $fell(irq_out_secondary) |-> $past(reg_wr, 2); endproperty
    property p_clr_zero; reg_rd && (reg_addr == 8'h7b || reg_addr == 8'h44) |=> reg_rdata == 8'h00; endproperty
    property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    property p_edge_pin; irq_out_primary && !$past(reg_wr) |=> irq_out_primary; endproperty
    a_mode: assert property (p_mode) else $error("mode flag wrong");
    a_rst_quiet: assert property (p_rst_quiet) else $error("pin high after reset");
    a_no_mask: assert property (p_no_mask) else $error("pin high with all masks off");
    a_hold_pri: assert property (p_hold_pri) else $error("primary pin fell without a write");
    a_hold_sec: assert property (p_hold_sec) else $error("secondary pin fell without a write");
    a_clr_zero: assert property (p_clr_zero) else $error("clear register read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    a_edge_pin: assert property (p_edge_pin) else $error("latched event lost from the pin");
    c_pri: cover property ($rose(irq_out_primary));
    c_sec: cover property ($rose(irq_out_secondary));
    c_mode: cover property ($rose(hdmi_mode_active));
endmodule

bind rxirq_core rxirq_props u_props (
    .clock, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .input_format_select,
    .edge_pulse, .irq_out_primary, .irq_out_secondary, .hdmi_mode_active
);

// *** sim/rxirq_host.sv ***
// Host controller model on the register port
module rxirq_host (
    input wire clock,
    input wire [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One-cycle write, leftovers inverted afterwards
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // One status byte per read, data taken one edge later
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        d = reg_rdata;
    endtask
endmodule

// *** sim/receiver_interrupt_status_logic_tb.sv ***
// Self-checking bench of the interrupt status core
module receiver_interrupt_status_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic sync_timing_valid_live = 1'b0, proc_lock_live = 1'b0, proc_unlock_live = 1'b0;
    logic ch1_sync_valid_live = 1'b0, ch1_lock_live = 1'b0, ch1_unlock_live = 1'b0;
    logic port_a_clock_present = 1'b0, port_b_clock_present = 1'b0;
    logic port_a_cable_present = 1'b0, port_b_cable_present = 1'b0;
    logic [27:0] level_src = 28'h0;
    logic [39:0] edge_pulse = 40'h0;
    logic [5:0] cec_flag_pulse = 6'h00;
    logic [7:0] cec_byte_pulse = 8'h00;
    logic [3:0] input_format_select = 4'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, k, e;
    logic reg_wr, reg_rd, irq_out_primary, irq_out_secondary, hdmi_mode_active;
    int failures = 0;
    int checked = 0;
    // Free-running clock
    always #10 clock = ~clock;
    rxirq_core DUT (
        .clock, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .level_src,
        .sync_timing_valid_live, .proc_lock_live, .proc_unlock_live, .ch1_sync_valid_live,
        .ch1_lock_live, .ch1_unlock_live, .port_a_clock_present, .port_b_clock_present,
        .port_a_cable_present, .port_b_cable_present, .input_format_select, .edge_pulse,
        .cec_flag_pulse, .cec_byte_pulse, .irq_out_primary, .irq_out_secondary, .hdmi_mode_active
    );
    rxirq_host host (.clock, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
    // Compares, counted
    task chk8(input string what, input [7:0] exp_v, input [7:0] got);
        checked++;
        if (got !== exp_v) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp_v, got);
        end
    endtask
    task chk1(input string what, input exp_v, input got);
        chk8(what, {7'h00, exp_v}, {7'h00, got});
    endtask
    // Settle, read one register, compare
    task rdchk(input [7:0] a, input [7:0] exp_v);
        repeat (3) @(posedge clock);
        host.rd(a, rv);
        chk8($sformatf("reg %h", a), exp_v, rv);
    endtask
    // One-cycle event pulse
    task pe(input [39:0] v);
        @(posedge clock);
        edge_pulse <= v;
        @(posedge clock);
        edge_pulse <= 40'h0;
    endtask
    // Bounded wait for the primary pin
    task wpin(input exp_v);
        for (int i = 0; i < 8 && irq_out_primary !== exp_v; i++) @(negedge clock);
        chk1("primary pin", exp_v, irq_out_primary);
        if (irq_out_primary !== exp_v) end_of_test;
    endtask
    // Level source drivers
    task setv(input v);
        @(posedge clock);
        sync_timing_valid_live <= v;
        ch1_sync_valid_live <= v;
    endtask
    task setlk(input v);
        @(posedge clock);
        proc_lock_live <= v;
        proc_unlock_live <= v;
        ch1_lock_live <= v;
        ch1_unlock_live <= v;
    endtask
    // Every edge group latches, holds and clears
    task t_edge;
        host.wr(8'h40, 8'h10);
        for (k = 8'h00; k < 8'h05; k++) begin
            pe(40'h1 << (8'h09 * k));
            rdchk(8'h79 + 8'h05 * k, 8'h01 << k);
            rdchk(8'h7a + 8'h05 * k, 8'h01 << k);
            host.wr(8'h7b + 8'h05 * k, 8'h01 << k);
            rdchk(8'h79 + 8'h05 * k, 8'h00);
            rdchk(8'h7a + 8'h05 * k, 8'h00);
        end
    endtask
    // Level raw follows its source both ways
    task t_level;
        for (k = 8'h00; k < 8'h04; k++) begin
            e = (k == 8'h03) ? 8'h10 : 8'h01;
            @(posedge clock);
            level_src <= 28'h1 << (8'h08 * k);
            rdchk(8'h60 + 8'h05 * k, e);
            @(posedge clock);
            level_src <= 28'h0;
            rdchk(8'h60 + 8'h05 * k, 8'h00);
            rdchk(8'h61 + 8'h05 * k, e);
            host.wr(8'h62 + 8'h05 * k, e);
        end
        host.wr(8'h40, 8'h00);
    endtask
    // Second event under a pending one
    task t_pin;
        host.wr(8'h7d, 8'h03);
        host.wr(8'h7c, 8'h01);
        host.wr(8'h41, 8'h31);
        pe(40'h1);
        wpin(1'b1);
        chk1("secondary pin", 1'b1, irq_out_secondary);
        pe(40'h2);
        repeat (6) @(negedge clock) chk1("primary held", 1'b1, irq_out_primary);
        rdchk(8'h7a, 8'h03);
        host.wr(8'h7b, 8'h01);
        rdchk(8'h7a, 8'h02);
        wpin(1'b1);
        chk1("secondary pin", 1'b0, irq_out_secondary);
        host.wr(8'h7b, 8'h02);
        wpin(1'b0);
        host.wr(8'h7d, 8'h00);
        host.wr(8'h7c, 8'h00);
        host.wr(8'h41, 8'h30);
    endtask
    // Sync valid and lock, main and channel groups, under both edge selects
    task t_sync;
        host.wr(8'h46, 8'h1c);
        host.wr(8'h5f, 8'h0e);
        setv(1'b1);
        rdchk(8'h43, 8'h10);
        rdchk(8'h5c, 8'h02);
        host.wr(8'h44, 8'h10);
        host.wr(8'h5d, 8'h02);
        rdchk(8'h42, 8'h10);
        rdchk(8'h5b, 8'h02);
        setv(1'b0);
        rdchk(8'h42, 8'h00);
        rdchk(8'h43, 8'h10);
        host.wr(8'h41, 8'h00);
        host.wr(8'h44, 8'h10);
        host.wr(8'h5d, 8'h02);
        setv(1'b1);
        rdchk(8'h43, 8'h10);
        rdchk(8'h5c, 8'h02);
        host.wr(8'h44, 8'h10);
        host.wr(8'h5d, 8'h02);
        rdchk(8'h42, 8'h00);
        rdchk(8'h5b, 8'h00);
        setv(1'b0);
        rdchk(8'h43, 8'h00);
        rdchk(8'h5c, 8'h00);
        setlk(1'b1);
        rdchk(8'h43, 8'h0c);
        rdchk(8'h5c, 8'h0c);
        host.wr(8'h43, 8'h00);
        rdchk(8'h43, 8'h0c);
        host.wr(8'h44, 8'h0c);
        host.wr(8'h5d, 8'h0c);
        setlk(1'b0);
        rdchk(8'h43, 8'h00);
        rdchk(8'h5c, 8'h00);
        host.wr(8'h41, 8'h30);
        setlk(1'b1);
        rdchk(8'h5c, 8'h0c);
        rdchk(8'h5b, 8'h0c);
        host.wr(8'h5d, 8'h0c);
        setlk(1'b0);
        rdchk(8'h5c, 8'h0c);
        rdchk(8'h5b, 8'h00);
        host.wr(8'h44, 8'h0c);
        host.wr(8'h5d, 8'h0c);
        rdchk(8'h43, 8'h00);
        host.wr(8'h46, 8'h00);
        host.wr(8'h5f, 8'h00);
    endtask
    // Forced interrupt, control event groups, mode flag, port bits
    task t_misc;
        host.wr(8'h4b, 8'h80);
        host.wr(8'h40, 8'h04);
        rdchk(8'h47, 8'h80);
        rdchk(8'h48, 8'h80);
        host.wr(8'h49, 8'h80);
        host.wr(8'h40, 8'h00);
        rdchk(8'h48, 8'h00);
        host.wr(8'h4b, 8'h00);
        host.wr(8'ha0, 8'h80);
        host.wr(8'h9b, 8'h20);
        @(posedge clock);
        cec_byte_pulse <= 8'h80;
        cec_flag_pulse <= 6'h20;
        @(posedge clock);
        cec_byte_pulse <= 8'h00;
        cec_flag_pulse <= 6'h00;
        rdchk(8'h9c, 8'h80);
        rdchk(8'h9d, 8'h80);
        rdchk(8'h97, 8'h20);
        rdchk(8'h98, 8'h20);
        host.wr(8'h9e, 8'h80);
        host.wr(8'h99, 8'h20);
        rdchk(8'h9d, 8'h00);
        rdchk(8'h97, 8'h00);
        host.wr(8'ha0, 8'h00);
        host.wr(8'h9b, 8'h00);
        @(posedge clock);
        port_a_clock_present <= 1'b1;
        port_b_clock_present <= 1'b1;
        port_a_cable_present <= 1'b1;
        port_b_cable_present <= 1'b1;
        rdchk(8'h6f, 8'h0f);
        for (k = 8'h04; k < 8'h08; k++) begin
            @(posedge clock);
            input_format_select <= k[3:0];
            repeat (3) @(negedge clock);
            chk1("mode flag", k == 8'h05 || k == 8'h06, hdmi_mode_active);
        end
    endtask
    // Verdict and stop
    task end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rdchk(8'h41, 8'h30);
        rdchk(8'h7d, 8'h00);
        rdchk(8'h7b, 8'h00);
        rdchk(8'h00, 8'h00);
        t_edge;
        t_level;
        t_pin;
        t_sync;
        t_misc;
        end_of_test;
    end
endmodule
